// file: wut_pkg.sv
// shared constants and bus carriers for the wake-up timer
package wut_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_COUNT_LOW     = 8'h00;
    localparam logic [7:0] OFF_COUNT_HIGH    = 8'h04;
    localparam logic [7:0] OFF_TIMER_CONTROL = 8'h08;
    localparam logic [7:0] OFF_TIMER_ENABLE  = 8'h0c;
    localparam logic [7:0] OFF_FIELD_A_LOW   = 8'h10;
    localparam logic [7:0] OFF_FIELD_A_HIGH  = 8'h14;
    localparam logic [7:0] OFF_FIELD_B_LOW   = 8'h18;
    localparam logic [7:0] OFF_FIELD_B_HIGH  = 8'h1c;
    localparam logic [7:0] OFF_FIELD_C_LOW   = 8'h20;
    localparam logic [7:0] OFF_FIELD_C_HIGH  = 8'h24;
    localparam logic [7:0] OFF_INT_ENABLE    = 8'h28;
    localparam logic [7:0] OFF_INT_STATUS    = 8'h2c;
    localparam logic [7:0] OFF_INT_CLEAR     = 8'h30;
    localparam logic [7:0] OFF_CAPTURE_LOW   = 8'h3c;
    localparam logic [7:0] OFF_CAPTURE_HIGH  = 8'h40;

    // timer_control field positions
    localparam int CTL_PRE_LO   = 0;
    localparam int CTL_FREE_RUN = 1;
    localparam int CTL_DIR      = 2;
    localparam int CTL_FREEZE   = 3;
    localparam int CTL_PRE_HI   = 4;
    localparam int CTL_SRC_LO   = 5;
    localparam int CTL_EVT_EN   = 7;
    localparam int CTL_EVT_LO   = 8;
    localparam logic [15:0] CTL_WR_MASK = 16'h0fff;

    // interrupt_status field positions
    localparam int ST_ROLL   = 3;
    localparam int ST_FREEZE = 7;
    localparam int ST_SYNC   = 8;

    // reset values
    localparam logic [15:0] CTL_RST     = 16'h0010;
    localparam logic [15:0] FA_LOW_RST  = 16'h1fff;
    localparam logic [15:0] FB_LOW_RST  = 16'h2fff;
    localparam logic [15:0] FC_LOW_RST  = 16'h3fff;
    localparam logic [15:0] HIGH_RST    = 16'h0000;

    // clock source codes
    localparam logic [1:0] SRC_PCLK = 2'b00;
    localparam logic [1:0] SRC_LF   = 2'b01;
    localparam logic [1:0] SRC_CORE = 2'b10;
    localparam logic [1:0] SRC_EXT  = 2'b11;

    // prescaler terminal counts (divide minus one)
    localparam logic [14:0] DIV1_TC   = 15'h0000;
    localparam logic [14:0] DIV4_TC   = 15'h0003;
    localparam logic [14:0] DIV16_TC  = 15'h000f;
    localparam logic [14:0] DIV256_TC = 15'h00ff;
    localparam logic [14:0] DIV32K_TC = 15'h7fff;

    // number of valid capture event codes
    localparam logic [3:0] EVT_COUNT = 4'hd;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } wut_apb_req_t;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } wut_apb_rsp_t;
endpackage : wut_pkg

// file: wut_timer.sv
// 32-bit wake-up timer with APB register slave
// Contract
// RULE1: 32-bit up/down counter behind a prescaler of 1 or 4, 16, 256, 32768.
// RULE2: counter clock from low-frequency oscillator, core, peripheral or external clock.
// RULE3: free-running counts full range then restarts at minimum or maximum.
// RULE4: periodic counts between start value and field C, then reloads.
// RULE5: enable bit 0 starts the timer, clearing it stops the timer.
// RULE6: enabled interrupts fire on target match or on rollover.
// RULE7: rollover interrupt only in free-running mode and only when enabled.
// RULE8: count is read as two 16-bit halves in two reads.
// RULE9: with freeze on, low read latches upper half; held until upper read.
// RULE10: software sets control bit 3 to use the freeze.
// RULE11: writing one to a clear bit clears that status flag.
// RULE12: software changes configuration only while timer is disabled.
// RULE13: enable writes raise status bit 8 until enable reaches timer domain.
// RULE14: capture works before start, counter advances only after enable.
// RULE15: counter compared with fields A, B, C; match can raise wake-up.
// RULE16: field C wins when several fields match together.
// RULE17: periodic mode resets count to start value on field C match.
// RULE18: free-running does not reset; software reprograms fields for more wake-ups.
// RULE19: each field interrupt enable also gates its wake-up pulse.
// RULE20: software disables a field enable before changing that field.
// RULE21: timer only raises wake-up interrupt; system wake is software's job.
// RULE22: control bit 2 selects up from zero or down from full scale.
// RULE23: control bits 6:5 select peripheral, oscillator, core or external clock.
// RULE24: control bits 11:8 pick one of thirteen capture events, bit 7 enables.
// RULE25: control bit 1 selects periodic (0) or free-running (1).
// RULE26: selected event stores the count into capture low and high.
//
// Decided for this implementation: register access over APB.
module wut_timer (
    input  wire logic                  i_sys_clk,
    input  wire logic                  i_srst,
    input  wire wut_pkg::wut_apb_req_t i_apb,
    output wut_pkg::wut_apb_rsp_t      o_apb,
    input  wire logic                  i_lf_osc,
    input  wire logic                  i_core_clock,
    input  wire logic                  i_external_clock_input,
    input  wire logic [12:0]           i_capture_events,
    output logic                       o_wakeup_irq,
    output logic [2:0]                 o_wake_pulse
);
    import wut_pkg::*;

    logic [2:0]  sync_q [3];
    logic [2:0]  lvl_q;
    logic [2:0]  rise;
    logic        src_edge;
    logic [15:0] ctrl_q;
    logic        enable_q;
    logic        run_q;
    logic        sync_pend_q;
    logic [14:0] presc_q;
    logic [14:0] presc_tc;
    logic        tick;
    logic        start;
    logic [31:0] cnt_q;
    logic [31:0] field_q [3];
    logic [3:0]  ien_q;
    logic [3:0]  flags_q;
    logic [3:0]  flag_set;
    logic [3:0]  flag_clr;
    logic [2:0]  match;
    logic        wrap;
    logic        frozen_q;
    logic [31:0] hold_q;
    logic [31:0] cap_q;
    logic [12:0] evt_q;
    logic [15:0] evt_rise;
    logic        capture;
    logic        acc;
    logic        wr_done;
    logic        rd_acc;
    logic [15:0] rdata;
    logic        hit;
    logic        pready_q;
    logic        pslverr_q;
    logic [31:0] prdata_q;
    logic        irq_q;
    logic [2:0]  pulse_q;

    // RULE25: mode, direction and field decode
    wire up      = ~ctrl_q[CTL_DIR];
    wire free    = ctrl_q[CTL_FREE_RUN];
    wire [1:0] src = ctrl_q[CTL_SRC_LO +: 2];
    wire [1:0] pre = {ctrl_q[CTL_PRE_HI], ctrl_q[CTL_PRE_LO]};
    wire [3:0] evt_sel = ctrl_q[CTL_EVT_LO +: 4];

    // terminal count: fast bus-side clocks use divide by 4 in the lowest setting
    function automatic logic [14:0] presc_term(input logic [1:0] code, input logic [1:0] s);
        logic [14:0] tc;
        tc = DIV1_TC;
        unique case (code)
            2'b00: tc = (s == SRC_LF || s == SRC_EXT) ? DIV1_TC : DIV4_TC;
            2'b01: tc = DIV16_TC;
            2'b10: tc = DIV256_TC;
            2'b11: tc = DIV32K_TC;
        endcase
        return tc;
    endfunction : presc_term

    // three-stage synchronisers for the foreign clock pins
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            for (int i = 0; i < 3; i++) begin
                sync_q[i] <= 3'h0;
            end
        end else begin
            sync_q[0] <= {sync_q[0][1:0], i_lf_osc};
            sync_q[1] <= {sync_q[1][1:0], i_core_clock};
            sync_q[2] <= {sync_q[2][1:0], i_external_clock_input};
        end
    end

    // accepted level moves only when stages two and three agree
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            lvl_q <= 3'h0;
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (sync_q[i][1] == sync_q[i][2]) begin
                    lvl_q[i] <= sync_q[i][2];
                end
            end
        end
    end

    // RULE2: source edge select
    // RULE23: decode of the select field
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            rise[i] = (sync_q[i][1] == sync_q[i][2]) & sync_q[i][2] & ~lvl_q[i];
        end
        unique case (src)
            SRC_PCLK: src_edge = 1'b1;
            SRC_LF:   src_edge = rise[0];
            SRC_CORE: src_edge = rise[1];
            SRC_EXT:  src_edge = rise[2];
        endcase
    end

    // bus phases: one wait state, writes land on the completing edge
    assign acc     = i_apb.psel & i_apb.penable & ~pready_q;
    assign wr_done = i_apb.psel & i_apb.penable & pready_q & i_apb.pwrite;
    assign rd_acc  = acc & ~i_apb.pwrite;

    // RULE13: enable crosses into the counter domain on a source edge
    // RULE5: run follows the enable bit
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            enable_q    <= 1'b0;
            run_q       <= 1'b0;
            sync_pend_q <= 1'b0;
        end else begin
            if (src_edge) begin
                run_q <= enable_q;
            end
            if (wr_done && i_apb.paddr == OFF_TIMER_ENABLE) begin
                enable_q    <= i_apb.pwdata[0];
                sync_pend_q <= 1'b1;
            end else if (src_edge) begin
                sync_pend_q <= 1'b0;
            end
        end
    end

    assign start    = src_edge & enable_q & ~run_q;
    assign presc_tc = presc_term(pre, src);
    assign tick     = src_edge & run_q & (presc_q == presc_tc);

    // RULE1: prescaler divides the selected source
    always_ff @(posedge i_sys_clk) begin
        if (i_srst || !run_q) begin
            presc_q <= 15'h0000;
        end else if (src_edge) begin
            presc_q <= tick ? 15'h0000 : presc_q + 15'h0001;
        end
    end

    // RULE15: compare against all three fields on each tick
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            match[i] = tick & (cnt_q == field_q[i]);
        end
        wrap = tick & (up ? (cnt_q == 32'hffffffff) : (cnt_q == 32'h00000000));
    end

    // RULE22: start value follows direction
    // RULE3: free-running wraps through the full range
    // RULE4: periodic reloads after field C
    // RULE17: field C reset without software
    // RULE14: counter holds until the enable reaches it
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            cnt_q <= 32'h00000000;
        end else if (start) begin
            cnt_q <= up ? 32'h00000000 : 32'hffffffff;
        end else if (tick) begin
            if (!free && match[2]) begin
                cnt_q <= up ? 32'h00000000 : 32'hffffffff;
            end else begin
                cnt_q <= up ? cnt_q + 32'h00000001 : cnt_q - 32'h00000001;
            end
        end
    end

    // RULE16: field C over B over A
    // RULE7: rollover only when free-running
    // RULE6: flags need their enable
    always_comb begin
        flag_set[2] = match[2] & ien_q[2];
        flag_set[1] = match[1] & ~match[2] & ien_q[1];
        flag_set[0] = match[0] & ~match[1] & ~match[2] & ien_q[0];
        flag_set[3] = wrap & free & ien_q[ST_ROLL];
        flag_clr    = (wr_done && i_apb.paddr == OFF_INT_CLEAR) ? i_apb.pwdata[3:0] : 4'h0;
    end

    // RULE11: clear bits drop flags, a new event wins
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            flags_q <= 4'h0;
        end else begin
            flags_q <= (flags_q & ~flag_clr) | flag_set;
        end
    end

    // RULE19: pulses gated like the flags
    // RULE21: besides the APB response, only the interrupt line and the wake pulses leave the block
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            pulse_q <= 3'h0;
            irq_q   <= 1'b0;
        end else begin
            pulse_q <= flag_set[2:0];
            irq_q   <= |flags_q;
        end
    end

    // configuration writes; no lock while running, software keeps to that
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            ctrl_q     <= CTL_RST;
            ien_q      <= 4'h0;
            field_q[0] <= {HIGH_RST, FA_LOW_RST};
            field_q[1] <= {HIGH_RST, FB_LOW_RST};
            field_q[2] <= {HIGH_RST, FC_LOW_RST};
        end else if (wr_done) begin
            unique case (i_apb.paddr)
                OFF_TIMER_CONTROL: ctrl_q <= i_apb.pwdata[15:0] & CTL_WR_MASK;
                OFF_INT_ENABLE:    ien_q <= i_apb.pwdata[3:0];
                OFF_FIELD_A_LOW:   field_q[0][15:0] <= i_apb.pwdata[15:0];
                OFF_FIELD_A_HIGH:  field_q[0][31:16] <= i_apb.pwdata[15:0];
                OFF_FIELD_B_LOW:   field_q[1][15:0] <= i_apb.pwdata[15:0];
                OFF_FIELD_B_HIGH:  field_q[1][31:16] <= i_apb.pwdata[15:0];
                OFF_FIELD_C_LOW:   field_q[2][15:0] <= i_apb.pwdata[15:0];
                OFF_FIELD_C_HIGH:  field_q[2][31:16] <= i_apb.pwdata[15:0];
                default: ;
            endcase
        end
    end

    // RULE9: low read snapshots, high read releases
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            frozen_q <= 1'b0;
            hold_q   <= 32'h00000000;
        end else if (!ctrl_q[CTL_FREEZE]) begin
            frozen_q <= 1'b0;
        end else if (rd_acc && i_apb.paddr == OFF_COUNT_LOW && !frozen_q) begin
            frozen_q <= 1'b1;
            hold_q   <= cnt_q;
        end else if (rd_acc && i_apb.paddr == OFF_COUNT_HIGH) begin
            frozen_q <= 1'b0;
        end
    end

    // RULE24: event select and enable
    // RULE26: capture the live count
    assign evt_rise = {3'h0, i_capture_events & ~evt_q};
    assign capture  = ctrl_q[CTL_EVT_EN] & (evt_sel < EVT_COUNT) & evt_rise[evt_sel];
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            evt_q <= 13'h0000;
            cap_q <= 32'h00000000;
        end else begin
            evt_q <= i_capture_events;
            if (capture) begin
                cap_q <= cnt_q;
            end
        end
    end

    // RULE8: read mux, count split in halves
    always_comb begin
        hit   = 1'b1;
        rdata = 16'h0000;
        unique case (i_apb.paddr)
            OFF_COUNT_LOW:     rdata = frozen_q ? hold_q[15:0] : cnt_q[15:0];
            OFF_COUNT_HIGH:    rdata = frozen_q ? hold_q[31:16] : cnt_q[31:16];
            OFF_TIMER_CONTROL: rdata = ctrl_q;
            OFF_TIMER_ENABLE:  rdata = {15'h0000, enable_q};
            OFF_FIELD_A_LOW:   rdata = field_q[0][15:0];
            OFF_FIELD_A_HIGH:  rdata = field_q[0][31:16];
            OFF_FIELD_B_LOW:   rdata = field_q[1][15:0];
            OFF_FIELD_B_HIGH:  rdata = field_q[1][31:16];
            OFF_FIELD_C_LOW:   rdata = field_q[2][15:0];
            OFF_FIELD_C_HIGH:  rdata = field_q[2][31:16];
            OFF_INT_ENABLE:    rdata = {12'h000, ien_q};
            OFF_INT_STATUS:    rdata = {7'h00, sync_pend_q, frozen_q, 3'h0, flags_q};
            OFF_INT_CLEAR:     rdata = 16'h0000;
            OFF_CAPTURE_LOW:   rdata = cap_q[15:0];
            OFF_CAPTURE_HIGH:  rdata = cap_q[31:16];
            default:           hit = 1'b0;
        endcase
    end

    // response registers; unmapped offsets answer with an error
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h00000000;
        end else begin
            pready_q  <= acc;
            pslverr_q <= acc & ~hit;
            prdata_q  <= rd_acc ? {16'h0000, rdata} : 32'h00000000;
        end
    end

    assign o_apb.pready  = pready_q;
    assign o_apb.pslverr = pslverr_q;
    assign o_apb.prdata  = prdata_q;
    assign o_wakeup_irq  = irq_q;
    assign o_wake_pulse  = pulse_q;

    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_srst);

    sequence s_low_read;
        rd_acc && i_apb.paddr == OFF_COUNT_LOW && ctrl_q[CTL_FREEZE] && !frozen_q;
    endsequence
    sequence s_high_read;
        rd_acc && i_apb.paddr == OFF_COUNT_HIGH;
    endsequence

    a_freeze_hold: assert property (s_low_read |=> frozen_q && hold_q == $past(cnt_q)) // RULE9
        else $error("low read did not freeze the count");
    a_freeze_release: assert property (frozen_q ##0 s_high_read |=> !frozen_q) // RULE9
        else $error("high read did not release the freeze");
    a_clear_flag: assert property (flag_clr[0] && !flag_set[0] |=> !flags_q[0]) // RULE11
        else $error("clear bit did not drop flag");
    a_set_wins: assert property (flag_set[1] |=> flags_q[1] ##1 irq_q) // RULE11
        else $error("set event lost or irq missing");
    a_sync_pend: assert property (wr_done && i_apb.paddr == OFF_TIMER_ENABLE |=> sync_pend_q) // RULE13
        else $error("enable write did not raise sync flag");
    a_periodic_reload: assert property (tick && !free && match[2] && up |=> cnt_q == 32'h00000000) // RULE17
        else $error("periodic reload missing");
    a_free_wrap: assert property (tick && free && !up && cnt_q == 32'h00000000 |=> cnt_q == 32'hffffffff) // RULE3
        else $error("free-running down wrap wrong");
    a_roll_free: assert property ($rose(flags_q[ST_ROLL]) |-> $past(free) && $past(ien_q[ST_ROLL])) // RULE7
        else $error("rollover flag outside free-running");
    a_stop_holds: assert property (!run_q && !start |=> $stable(cnt_q)) // RULE14
        else $error("counter moved while stopped");
    a_field_prio: assert property (match[2] && match[0] |-> !flag_set[0]) // RULE16
        else $error("field A flagged over field C");
    a_pulse_gate: assert property (o_wake_pulse[1] |-> $past(ien_q[1]) && $past(match[1])) // RULE19
        else $error("pulse without enable and match");
    a_capture_take: assert property (capture |=> cap_q == $past(cnt_q)) // RULE26
        else $error("capture did not store count");
    a_bus_answer: assert property (acc |=> pready_q ##1 !pready_q) // RULE8
        else $error("bus answer timing wrong");
endmodule : wut_timer

// file: wake_up_timer_32bit_bench.sv
// self-checking bench for the wake-up timer, driven over its register bus
module wake_up_timer_32bit_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import wut_pkg::*;

    logic         i_sys_clk = 1'b0;
    logic         i_srst    = 1'b1;
    wut_apb_req_t apb_req   = '0;
    wut_apb_rsp_t apb_rsp;
    logic         lf_osc    = 1'b0;
    logic         core_clk  = 1'b0;
    logic         ext_clk   = 1'b0;
    logic         lf_run    = 1'b1;
    logic [12:0]  events    = 13'h0000;
    logic         irq;
    logic [2:0]   pulse;
    logic [31:0]  rd;
    logic [31:0]  cap;
    logic         err;
    int           cyc       = 0;
    int           pcnt [3];
    int           failures  = 0;
    int           tests_run = 0;

    // control, cycles and expected count: pclk div4/16/256, down, oscillator, core, external
    localparam logic [15:0] CASE_CTL [7] = '{16'h0002, 16'h0003, 16'h0012, 16'h0006, 16'h0022, 16'h0042, 16'h0062};
    localparam int          CASE_CYC [7] = '{200, 320, 2560, 200, 320, 640, 240};
    localparam logic [31:0] CASE_EXP [7] = '{32'h32, 32'h14, 32'h0a, 32'hffffffcd, 32'h14, 32'h14, 32'h14};
    localparam logic [7:0]  RST_ADR [13] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20,
                                             8'h24, 8'h28, 8'h2c, 8'h30};
    localparam logic [15:0] RST_VAL [13] = '{16'h0, 16'h0, 16'h0010, 16'h0, 16'h1fff, 16'h0, 16'h2fff, 16'h0,
                                             16'h3fff, 16'h0, 16'h0, 16'h0, 16'h0};

    // 8 ns system clock
    always #4 i_sys_clk = ~i_sys_clk;

    wut_timer DUT (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_apb(apb_req), .o_apb(apb_rsp),
        .i_lf_osc(lf_osc), .i_core_clock(core_clk), .i_external_clock_input(ext_clk),
        .i_capture_events(events), .o_wakeup_irq(irq), .o_wake_pulse(pulse));

    // slow source pins; the oscillator can be held still to keep the sync flag pending
    always @(posedge i_sys_clk) begin
        cyc      <= cyc + 1;
        core_clk <= cyc[2];
        lf_osc   <= lf_run & cyc[3];
        ext_clk  <= (cyc % 12) < 6;
    end

    // wake pulse counters per field
    always @(posedge i_sys_clk) begin
        for (int i = 0; i < 3; i++)
            if (pulse[i] === 1'b1)
                pcnt[i] <= pcnt[i] + 1;
    end

    task automatic check_eq(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : check_eq

    task automatic check_rng(input string name, input logic [31:0] lo, input logic [31:0] hi,
                             input logic [31:0] got);
        tests_run++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            failures++;
            $display("mismatch %s expected %h..%h seen %h", name, lo, hi, got);
        end
    endtask : check_rng

    // one transfer: setup, access held until pready is sampled high
    task automatic apb_xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
        @(posedge i_sys_clk);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wdata};
        @(posedge i_sys_clk);
        apb_req.penable <= 1'b1;
        // no local limit: the watchdog ends a hung transfer
        do begin
            @(posedge i_sys_clk);
        end while (apb_rsp.pready !== 1'b1);
        rd  = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        apb_req.psel    <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask : apb_xfer

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        apb_xfer(1'b1, a, {16'h0000, d});
    endtask : wr

    task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
        apb_xfer(1'b0, a, 32'h0);
        check_eq(name, exp, rd);
    endtask : rd_chk

    // polls until the enable change has reached the timer domain
    task automatic wait_sync;
        int n = 0;
        do begin
            apb_xfer(1'b0, OFF_INT_STATUS, 32'h0);
            n++;
        end while (rd[ST_SYNC] !== 1'b0 && n < 64);
        check_eq("sync pending", 32'h0, {31'h0, rd[ST_SYNC]});
        if (rd[ST_SYNC] !== 1'b0)
            finish_test();
    endtask : wait_sync

    task automatic stop_timer;
        wr(OFF_TIMER_ENABLE, 16'h0000);
        wait_sync();
    endtask : stop_timer

    task automatic pulse_event(input logic [12:0] mask);
        @(posedge i_sys_clk);
        events <= mask;
        repeat (2) @(posedge i_sys_clk);
        events <= 13'h0000;
    endtask : pulse_event

    // run for a span, stop, then read the held count; slack covers start and stop sync
    task automatic run_case(input logic [15:0] ctl, input int cycles, input logic [31:0] exp);
        logic [31:0] lo;
        wr(OFF_TIMER_CONTROL, ctl);
        wr(OFF_TIMER_ENABLE, 16'h0001);
        repeat (cycles) @(posedge i_sys_clk);
        stop_timer();
        apb_xfer(1'b0, OFF_COUNT_LOW, 32'h0);
        lo = rd;
        check_rng("count_low", {16'h0, exp[15:0] - 16'h3}, {16'h0, exp[15:0] + 16'h3}, lo);
        rd_chk("count_high", OFF_COUNT_HIGH, {16'h0, exp[31:16]});
        rd_chk("count_low stopped", OFF_COUNT_LOW, lo);
    endtask : run_case

    task automatic finish_test;
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : finish_test

    // watchdog well beyond the expected run of some 6k cycles
    initial begin
        #400000;
        failures++;
        $display("mismatch watchdog expected done seen timeout");
        finish_test();
    end

    initial begin
        pcnt = '{0, 0, 0};
        repeat (16) @(posedge i_sys_clk);
        i_srst <= 1'b0;
        for (int i = 0; i < 13; i++)
            rd_chk($sformatf("reset %h", RST_ADR[i]), RST_ADR[i], {16'h0, RST_VAL[i]});
        apb_xfer(1'b0, 8'h34, 32'h0);
        check_eq("unmapped error", 32'h1, {31'h0, err});
        apb_xfer(1'b1, 8'h02, 32'h0);
        check_eq("misaligned error", 32'h1, {31'h0, err});
        wr(OFF_COUNT_LOW, 16'h1234);
        rd_chk("count read-only", OFF_COUNT_LOW, 32'h0);
        wr(OFF_TIMER_CONTROL, 16'hffff);
        rd_chk("control mask", OFF_TIMER_CONTROL, 32'h0fff);
        // capture: before start, while running, and with an unused event code
        wr(OFF_TIMER_CONTROL, 16'h0382);
        pulse_event(13'h0008);
        rd_chk("capture before start", OFF_CAPTURE_LOW, 32'h0);
        wr(OFF_TIMER_ENABLE, 16'h0001);
        repeat (100) @(posedge i_sys_clk);
        pulse_event(13'h0008);
        apb_xfer(1'b0, OFF_CAPTURE_LOW, 32'h0);
        cap = rd;
        check_rng("capture_low", 32'h12, 32'h20, cap);
        rd_chk("capture_high", OFF_CAPTURE_HIGH, 32'h0);
        stop_timer();
        wr(OFF_TIMER_CONTROL, 16'h0d82);
        wr(OFF_TIMER_ENABLE, 16'h0001);
        repeat (40) @(posedge i_sys_clk);
        pulse_event(13'h1fff);
        rd_chk("capture unused code", OFF_CAPTURE_LOW, cap);
        stop_timer();
        // sync flag stays up while the oscillator source is still
        @(posedge i_sys_clk);
        lf_run <= 1'b0;
        wr(OFF_TIMER_CONTROL, 16'h0022);
        wr(OFF_TIMER_ENABLE, 16'h0001);
        rd_chk("sync raised", OFF_INT_STATUS, 32'h0100);
        lf_run <= 1'b1;
        wait_sync();
        stop_timer();
        for (int i = 0; i < 7; i++)
            run_case(CASE_CTL[i], CASE_CYC[i], CASE_EXP[i]);
        // freeze on low read, released by the high read
        wr(OFF_TIMER_CONTROL, 16'h000a);
        wr(OFF_TIMER_ENABLE, 16'h0001);
        repeat (40) @(posedge i_sys_clk);
        apb_xfer(1'b0, OFF_COUNT_LOW, 32'h0);
        cap = rd;
        repeat (40) @(posedge i_sys_clk);
        rd_chk("frozen low", OFF_COUNT_LOW, cap);
        rd_chk("frozen flag", OFF_INT_STATUS, 32'h0080);
        rd_chk("frozen high", OFF_COUNT_HIGH, 32'h0);
        rd_chk("freeze released", OFF_INT_STATUS, 32'h0);
        stop_timer();
        // periodic with all three fields equal: field C wins and reloads
        wr(OFF_FIELD_A_LOW, 16'h0008);
        wr(OFF_FIELD_B_LOW, 16'h0008);
        wr(OFF_FIELD_C_LOW, 16'h0008);
        wr(OFF_INT_ENABLE, 16'h0007);
        wr(OFF_TIMER_CONTROL, 16'h0000);
        pcnt = '{0, 0, 0};
        wr(OFF_TIMER_ENABLE, 16'h0001);
        repeat (400) @(posedge i_sys_clk);
        apb_xfer(1'b0, OFF_COUNT_LOW, 32'h0);
        check_rng("periodic count", 32'h0, 32'h8, rd);
        rd_chk("periodic high", OFF_COUNT_HIGH, 32'h0);
        check_eq("irq raised", 32'h1, {31'h0, irq});
        stop_timer();
        rd_chk("priority status", OFF_INT_STATUS, 32'h0004);
        check_eq("pulse a", 32'h0, pcnt[0]);
        check_eq("pulse b", 32'h0, pcnt[1]);
        check_rng("pulse c", 32'h8, 32'he, pcnt[2]);
        wr(OFF_INT_CLEAR, 16'h0004);
        rd_chk("cleared status", OFF_INT_STATUS, 32'h0);
        check_eq("irq cleared", 32'h0, {31'h0, irq});
        // field C gated off still reloads; rollover enable has no effect in periodic mode
        wr(OFF_INT_ENABLE, 16'h0000);
        wr(OFF_FIELD_A_LOW, 16'h0003);
        wr(OFF_FIELD_B_LOW, 16'h0005);
        wr(OFF_INT_ENABLE, 16'h000b);
        pcnt = '{0, 0, 0};
        wr(OFF_TIMER_ENABLE, 16'h0001);
        repeat (400) @(posedge i_sys_clk);
        stop_timer();
        rd_chk("gated status", OFF_INT_STATUS, 32'h0003);
        check_rng("pulse a gated on", 32'h8, 32'he, pcnt[0]);
        check_rng("pulse b gated on", 32'h8, 32'he, pcnt[1]);
        check_eq("pulse c gated off", 32'h0, pcnt[2]);
        // free-running passes field C without reload: one wake-up until reprogrammed
        wr(OFF_INT_CLEAR, 16'h000f);
        wr(OFF_INT_ENABLE, 16'h0004);
        wr(OFF_TIMER_CONTROL, 16'h0002);
        pcnt = '{0, 0, 0};
        wr(OFF_TIMER_ENABLE, 16'h0001);
        repeat (200) @(posedge i_sys_clk);
        stop_timer();
        rd_chk("free status", OFF_INT_STATUS, 32'h0004);
        apb_xfer(1'b0, OFF_COUNT_LOW, 32'h0);
        check_rng("free no reload", 32'h20, 32'h40, rd);
        check_eq("free single wake", 32'h1, pcnt[2]);
        finish_test();
    end
endmodule : wake_up_timer_32bit_bench
